// File: core/cca_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef CCA_REGS_SVH
`define CCA_REGS_SVH
`define CCA_ADR_TA_CNT 8'h00
`define CCA_ADR_TA_RLD 8'h04
`define CCA_ADR_TB_CNT 8'h08
`define CCA_ADR_TB_RLD 8'h0C
`define CCA_ADR_RUN 8'h10
`define CCA_ADR_FLAG 8'h14
`define CCA_ADR_CHV 8'h20
`define CCA_ADR_CHC 8'h40
`define CCA_ADR_CH_MASK 8'hE3
`define CCA_ADR_IDX_LSB 2
`define CCA_ADR_IDX_W 3
`define CCA_RUN_A_BIT 0
`define CCA_RUN_B_BIT 1
`define CCA_CTL_MODE_LSB 0
`define CCA_CTL_MODE_W 3
`define CCA_CTL_TSEL_BIT 3
`define CCA_CTL_DBL_BIT 4
`define CCA_CTL_W 5
`define CCA_RST_CNT 16'h0000
`define CCA_RST_RLD 16'h0000
`define CCA_RST_CHV 16'h0000
`define CCA_RST_CTL 5'h00
`define CCA_RST_RUN 2'h0
`define CCA_TMR_MAX 16'hFFFF
`define CCA_CLK_NS 10
`define CCA_TCL_NS 5
`define CCA_RES_TCL 16
`define CCA_TICK_CYC ((`CCA_RES_TCL * `CCA_TCL_NS) / `CCA_CLK_NS)
`endif

// File: core/cca_pkg.sv
// types shared by the capture/compare array
`include "cca_regs.svh"
package cca_pkg;
  localparam int NCH = 8;
  localparam int NPAIR = NCH / 2;
  localparam int DW = 16;
  localparam int CW = `CCA_CTL_W;

  typedef enum logic [2:0] {
    cca_off = 3'h0,
    cca_cap_rise = 3'h1,
    cca_cap_fall = 3'h2,
    cca_cap_both = 3'h3,
    cca_cmp0 = 3'h4,
    cca_cmp1 = 3'h5,
    cca_cmp2 = 3'h6,
    cca_cmp3 = 3'h7
  } cca_mode_e;

  typedef struct packed {
    logic [DW-1:0] cnt;
    logic [7:0] div;
    logic stepped;
    logic ovf;
  } cca_tmr_s;

  typedef struct packed {
    logic [NCH-1:0][DW-1:0] val;
    logic [NCH-1:0][CW-1:0] ctl;
    logic [DW-1:0] rld_a;
    logic [DW-1:0] rld_b;
    logic [1:0] run;
    logic [NCH-1:0] s1;
    logic [NCH-1:0] s2;
    logic [NCH-1:0] s3;
    logic [NCH-1:0] filt;
    logic [NCH-1:0] pin;
    logic [NCH-1:0] done;
    logic [NCH-1:0] flag;
    logic [NCH-1:0] irq;
    logic [DW-1:0] rdata;
  } cca_st_s;
endpackage : cca_pkg

// File: core/cca_timer.sv
// reloadable 16-bit time base with fixed tick divider
`timescale 1ns/1ps
`include "cca_regs.svh"
module cca_timer #(
  parameter int DIV = `CCA_TICK_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic load,
  input wire logic [15:0] load_val,
  input wire logic [15:0] reload,
  output logic [15:0] cnt,
  output logic stepped,
  output logic ovf
);
  cca_pkg::cca_tmr_s q;
  cca_pkg::cca_tmr_s d;

  if (DIV < 1 || DIV > 256) begin : g_chk
    $error("cca_timer: DIV must be 1 to 256");
  end

  always_comb begin
    d = q;
    d.stepped = 1'b0;
    d.ovf = 1'b0;
    if (load) begin
      d.cnt = load_val;
      d.div = 8'h00;
    end else if (run) begin
      // one count per sixteen phase units
      if (q.div == 8'(DIV - 1)) begin
        d.div = 8'h00;
        d.stepped = 1'b1;
        if (q.cnt == `CCA_TMR_MAX) begin
          d.cnt = reload;
          d.ovf = 1'b1;
        end else begin
          d.cnt = q.cnt + 16'h0001;
        end
      end else begin
        d.div = q.div + 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign cnt = q.cnt;
  assign stepped = q.stepped;
  assign ovf = q.ovf;
endmodule : cca_timer

// File: core/cca_top.sv
// eight-channel capture/compare array on two reloadable timers
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "cca_regs.svh"
// Overview of operation
// - eight channels, count step every sixteen phase units
// - two independent reloadable 16-bit timers
// - each channel picks timer and capture/compare
// - one pin per channel, input or output
// - capture copies assigned timer into channel
// - capture raises that channel's interrupt request
// - capture edge: rising, falling or both
// - compare channels checked on every count
// - mode 0 interrupt only, many per period
// - mode 1 toggles pin each match
// - mode 2 interrupt at most once per period
// - mode 3 sets pin, overflow clears it
// - paired registers toggle one shared pin
module cca_top #(
  parameter int NCH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic we,
  input wire logic re,
  output logic [15:0] rdata,
  input wire logic [NCH-1:0] chan_pin_i,
  output logic [NCH-1:0] chan_pin_o,
  output logic [NCH-1:0] chan_pin_oe,
  output logic [NCH-1:0] chan_irq
);
  localparam int NPAIR = NCH / 2;
  localparam int DW = cca_pkg::DW;
  localparam int CW = cca_pkg::CW;

  if (NCH != cca_pkg::NCH) begin : g_chk
    $error("cca_top: pairing is wired for eight channels only");
  end

  cca_pkg::cca_st_s q;
  cca_pkg::cca_st_s d;

  logic [15:0] ta_cnt;
  logic [15:0] tb_cnt;
  logic ta_step;
  logic tb_step;
  logic ta_ovf;
  logic tb_ovf;
  logic ta_load;
  logic tb_load;
  logic [NCH-1:0][DW-1:0] tval;
  logic [NCH-1:0] tstep;
  logic [NCH-1:0] tovf;
  logic [NCH-1:0] filt_nx;
  logic [NCH-1:0] cap_ev;
  logic [NCH-1:0] match;
  logic [NCH-1:0] pair_dbl;
  logic [NCH-1:0] oe;
  cca_pkg::cca_mode_e mode [NCH];

  ////////////////////////////////////////////////////////////////////////////
  // time bases

  assign ta_load = we && (addr == `CCA_ADR_TA_CNT);
  assign tb_load = we && (addr == `CCA_ADR_TB_CNT);

  cca_timer #(.DIV(`CCA_TICK_CYC)) u_tmr_a (
    .clk(clk),
    .rst(rst),
    .run(q.run[`CCA_RUN_A_BIT]),
    .load(ta_load),
    .load_val(wdata),
    .reload(q.rld_a),
    .cnt(ta_cnt),
    .stepped(ta_step),
    .ovf(ta_ovf)
  );

  cca_timer #(.DIV(`CCA_TICK_CYC)) u_tmr_b (
    .clk(clk),
    .rst(rst),
    .run(q.run[`CCA_RUN_B_BIT]),
    .load(tb_load),
    .load_val(wdata),
    .reload(q.rld_b),
    .cnt(tb_cnt),
    .stepped(tb_step),
    .ovf(tb_ovf)
  );

  ////////////////////////////////////////////////////////////////////////////
  // per-channel decode

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic tsel;
    logic rise;
    logic fall;
    logic is_cmp;
    assign mode[i] = cca_pkg::cca_mode_e'(
      q.ctl[i][`CCA_CTL_MODE_LSB +: `CCA_CTL_MODE_W]);
    assign tsel = q.ctl[i][`CCA_CTL_TSEL_BIT];
    assign tval[i] = tsel ? tb_cnt : ta_cnt;
    assign tstep[i] = tsel ? tb_step : ta_step;
    assign tovf[i] = tsel ? tb_ovf : ta_ovf;
    // filtered level moves only when the two later stages agree
    assign filt_nx[i] = (q.s2[i] == q.s3[i]) ? q.s3[i] : q.filt[i];
    assign rise = filt_nx[i] && !q.filt[i];
    assign fall = !filt_nx[i] && q.filt[i];
    assign cap_ev[i] = (mode[i] == cca_pkg::cca_cap_rise && rise) ||
      (mode[i] == cca_pkg::cca_cap_fall && fall) ||
      (mode[i] == cca_pkg::cca_cap_both && (rise || fall));
    assign is_cmp = mode[i] inside {cca_pkg::cca_cmp0, cca_pkg::cca_cmp1,
      cca_pkg::cca_cmp2, cca_pkg::cca_cmp3};
    assign match[i] = is_cmp && tstep[i] && (q.val[i] == tval[i]);
    assign pair_dbl[i] = q.ctl[i % NPAIR][`CCA_CTL_DBL_BIT];
    // in a pair the lower channel always drives and the upper never; unpaired, pin drives only for compare modes 1 and 3
    assign oe[i] = pair_dbl[i] ? (i < NPAIR) :
      (mode[i] == cca_pkg::cca_cmp1 || mode[i] == cca_pkg::cca_cmp3);
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [NCH-1:0] hit;
    logic [`CCA_ADR_IDX_W-1:0] idx;
    hit = '0;
    idx = addr[`CCA_ADR_IDX_LSB +: `CCA_ADR_IDX_W];
    d = q;
    d.irq = '0;
    d.rdata = '0;
    d.s1 = chan_pin_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.filt = filt_nx;
    if (we) begin
      case (addr)
        `CCA_ADR_TA_RLD: d.rld_a = wdata;
        `CCA_ADR_TB_RLD: d.rld_b = wdata;
        `CCA_ADR_RUN: d.run = wdata[1:0];
        `CCA_ADR_FLAG: d.flag = q.flag & ~wdata[NCH-1:0];
        default: ;
      endcase
      if ((addr & `CCA_ADR_CH_MASK) == `CCA_ADR_CHV) begin
        d.val[idx] = wdata;
      end
      if ((addr & `CCA_ADR_CH_MASK) == `CCA_ADR_CHC) begin
        d.ctl[idx] = wdata[CW-1:0];
      end
    end
    for (int i = 0; i < NCH; i++) begin
      // capture wins over a software write
      if (cap_ev[i]) begin
        d.val[i] = tval[i];
        hit[i] = 1'b1;
      end
      if (pair_dbl[i]) begin
        // either register of the pair toggles the shared pin
        if (i < NPAIR && (match[i] || match[(i + NPAIR) % NCH])) begin
          d.pin[i] = ~q.pin[i];
        end
        hit[i] = hit[i] | match[i];
      end else begin
        unique case (mode[i])
          cca_pkg::cca_cmp0: hit[i] = hit[i] | match[i];
          cca_pkg::cca_cmp1: begin
            if (match[i]) begin
              d.pin[i] = ~q.pin[i];
              hit[i] = 1'b1;
            end
          end
          cca_pkg::cca_cmp2: begin
            if (tovf[i]) begin
              d.done[i] = 1'b0;
            end
            if (match[i] && !d.done[i]) begin
              d.done[i] = 1'b1;
              hit[i] = 1'b1;
            end
          end
          cca_pkg::cca_cmp3: begin
            // low at overflow, high at first match
            if (tovf[i]) begin
              d.pin[i] = 1'b0;
              d.done[i] = 1'b0;
            end
            if (match[i] && !d.done[i]) begin
              d.pin[i] = 1'b1;
              d.done[i] = 1'b1;
              hit[i] = 1'b1;
            end
          end
          cca_pkg::cca_off, cca_pkg::cca_cap_rise,
          cca_pkg::cca_cap_fall, cca_pkg::cca_cap_both: d.done[i] = 1'b0;
        endcase
      end
      // request per channel; set beats the software clear
      if (hit[i]) begin
        d.irq[i] = 1'b1;
        d.flag[i] = 1'b1;
      end
    end
    if (re) begin
      case (addr)
        `CCA_ADR_TA_CNT: d.rdata = ta_cnt;
        `CCA_ADR_TA_RLD: d.rdata = q.rld_a;
        `CCA_ADR_TB_CNT: d.rdata = tb_cnt;
        `CCA_ADR_TB_RLD: d.rdata = q.rld_b;
        `CCA_ADR_RUN: d.rdata = DW'(q.run);
        `CCA_ADR_FLAG: d.rdata = DW'(q.flag);
        default: ;
      endcase
      if ((addr & `CCA_ADR_CH_MASK) == `CCA_ADR_CHV) begin
        d.rdata = q.val[idx];
      end
      if ((addr & `CCA_ADR_CH_MASK) == `CCA_ADR_CHC) begin
        d.rdata = DW'(q.ctl[idx]);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rdata = q.rdata;
  assign chan_pin_o = q.pin;
  assign chan_pin_oe = oe;
  assign chan_irq = q.irq;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_res;
    ta_step |=> !ta_step [*7];
  endproperty
  a_res: assert property (p_res)
    else $error("timer a stepped faster than one count per 8 clocks");

  property p_count;
    (ta_step && !ta_ovf) |-> ta_cnt == $past(ta_cnt) + 16'h0001;
  endproperty
  a_count: assert property (p_count)
    else $error("timer a did not advance by one");

  property p_reload;
    ta_ovf |-> ta_step && ta_cnt == $past(q.rld_a);
  endproperty
  a_reload: assert property (p_reload)
    else $error("timer a overflow did not load reload value");

  for (genvar i = 0; i < NCH; i++) begin : g_chk_ch
    sequence s_spent;
      !pair_dbl[i] && mode[i] == cca_pkg::cca_cmp2 && q.done[i] && !tovf[i];
    endsequence

    property p_cap_val;
      cap_ev[i] |=> q.val[i] == $past(tval[i]);
    endproperty
    a_cap_val: assert property (p_cap_val)
      else $error("capture did not latch timer value");

    property p_cap_irq;
      cap_ev[i] |=> q.irq[i] && q.flag[i];
    endproperty
    a_cap_irq: assert property (p_cap_irq)
      else $error("capture did not raise request");

    property p_edge_sel;
      (mode[i] == cca_pkg::cca_cap_rise && q.filt[i] && !filt_nx[i] && !we)
        |=> $stable(q.val[i]) && !q.irq[i];
    endproperty
    a_edge_sel: assert property (p_edge_sel)
      else $error("rising-edge capture fired on a falling edge");

    property p_cmp0;
      (!pair_dbl[i] && mode[i] == cca_pkg::cca_cmp0 && match[i])
        |=> q.irq[i] && $stable(q.pin[i]);
    endproperty
    a_cmp0: assert property (p_cmp0)
      else $error("mode 0 match wrong");

    property p_cmp1;
      (!pair_dbl[i] && mode[i] == cca_pkg::cca_cmp1 && match[i])
        |=> q.pin[i] != $past(q.pin[i]) && q.irq[i];
    endproperty
    a_cmp1: assert property (p_cmp1)
      else $error("mode 1 match did not toggle pin");

    property p_cmp2_once;
      (s_spent ##0 match[i]) |=> !q.irq[i];
    endproperty
    a_cmp2_once: assert property (p_cmp2_once)
      else $error("mode 2 gave a second request in one period");

    property p_cmp3_low;
      (!pair_dbl[i] && mode[i] == cca_pkg::cca_cmp3 && tovf[i] && !match[i])
        |=> !q.pin[i];
    endproperty
    a_cmp3_low: assert property (p_cmp3_low)
      else $error("mode 3 pin not cleared at overflow");

    if (i < NPAIR) begin : g_pair
      property p_dbl;
        (pair_dbl[i] && (match[i] || match[i + NPAIR]))
          |=> q.pin[i] != $past(q.pin[i]);
      endproperty
      a_dbl: assert property (p_dbl)
        else $error("paired match did not toggle shared pin");
    end
  end
endmodule : cca_top

// File: testbench/cca_pin_model.sv
// far-side model of the signals on the channel pins
`timescale 1ns/1ps
module cca_pin_model (
  input wire logic clk,
  input wire logic [7:0] lvl,
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe,
  output logic [7:0] pin_i
);
  // outside source moves only after an edge, like a synchronous driver
  logic [7:0] ext_q = 8'h00;
  always_ff @(posedge clk) begin
    ext_q <= lvl;
  end
  // where the array drives a pin its level wins on the wire
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_q);
endmodule : cca_pin_model

// File: testbench/capture_compare_array_bench.sv
// self-checking bench for the capture/compare array
`timescale 1ns/1ps
`include "cca_regs.svh"
module capture_compare_array_bench;
  logic clk, rst, we, re, rd_pend;
  logic [7:0] addr, lvl, pin_i, pin_o, pin_oe, irq;
  logic [15:0] wdata, rdata, v1, v2, ev, cexp;
  logic [15:0] rd_q[$];
  logic [15:0] cv[7] = '{16'hFFF2, 16'hFFF4, 16'hFFF4, 16'hFFF6,
    16'hFFF8, 16'h0000, 16'hFFF2};
  logic [15:0] cc[7] = '{16'h0014, 16'h0005, 16'h0006, 16'h0007,
    16'h0004, 16'h0000, 16'h0004};
  int err_total, num_checks;
  int irq_cnt[8];
  int irq_exp[8] = '{2, 2, 2, 2, 2, 0, 3, 0};

  cca_top #(.NCH(8)) i_dut (.clk(clk), .rst(rst), .addr(addr),
    .wdata(wdata), .we(we), .re(re), .rdata(rdata), .chan_pin_i(pin_i),
    .chan_pin_o(pin_o), .chan_pin_oe(pin_oe), .chan_irq(irq));
  cca_pin_model i_pins (.clk(clk), .lvl(lvl), .pin_o(pin_o),
    .pin_oe(pin_oe), .pin_i(pin_i));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [15:0] e,
    input logic [15:0] s);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    re <= 1'b1;
    addr <= a;
    rd_q.push_back(e);
    @(posedge clk);
    re <= 1'b0;
  endtask : rd

  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  ////////////////////////////////////////////////////////////////////////
  // read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_pend) begin
      ev = rd_q.pop_front();
      chk("rdata", ev, rdata);
    end
    rd_pend <= re && !rst;
    for (int i = 0; i < 8; i++) begin
      if (!rst && irq[i] === 1'b1) irq_cnt[i]++;
    end
  end

  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(5));
    rst = 1'b1;
    we = 1'b0;
    re = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
    lvl = 8'h00;
    rd_pend = 1'b0;
    cexp = 16'h0000;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(`CCA_ADR_TA_CNT, 16'h0000);
    rd(`CCA_ADR_RUN, 16'h0000);
    rd(8'h18, 16'h0000);
    // timer_b held still so the captured count is known
    for (int m = 1; m <= 3; m++) begin
      v1 = 16'($urandom());
      v2 = 16'($urandom());
      wr(`CCA_ADR_CHC + 8'h1C, 16'(m) | 16'h0008);
      wr(`CCA_ADR_TB_CNT, v1);
      lvl[7] <= 1'b1;
      repeat (10) @(posedge clk);
      wr(`CCA_ADR_TB_CNT, v2);
      lvl[7] <= 1'b0;
      repeat (10) @(posedge clk);
      if (m != 2) begin
        cexp = v1;
        irq_exp[7]++;
      end
      if (m != 1) begin
        cexp = v2;
        irq_exp[7]++;
      end
      rd(`CCA_ADR_CHV + 8'h1C, cexp);
    end
    rd(`CCA_ADR_FLAG, 16'h0080);
    wr(`CCA_ADR_FLAG, 16'h0080);
    rd(`CCA_ADR_FLAG, 16'h0000);
    // period of sixteen counts: FFF0 up to FFFF, then reload
    wr(`CCA_ADR_TA_RLD, 16'hFFF0);
    wr(`CCA_ADR_TA_CNT, 16'hFFF0);
    for (int i = 0; i < 7; i++) begin
      wr(`CCA_ADR_CHV + 8'(4 * i), cv[i]);
      wr(`CCA_ADR_CHC + 8'(4 * i), cc[i]);
    end
    wr(`CCA_ADR_RUN, 16'h0001);
    repeat (51) @(posedge clk);
    #1;
    chk("pin_oe", 16'h000B, {8'h00, pin_oe});
    chk("pin_o step 6", 16'h000B, {8'h00, pin_o & 8'h0B});
    repeat (112) @(posedge clk);
    #1;
    chk("pin_o step 20", 16'h0001, {8'h00, pin_o & 8'h0B});
    // moving the match later: mode 2 stays quiet, mode 0 fires again
    wr(`CCA_ADR_CHV + 8'h08, 16'hFFF8);
    wr(`CCA_ADR_CHV + 8'h18, 16'hFFF8);
    repeat (30) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      chk("irq count", 16'(irq_exp[i]), 16'(irq_cnt[i]));
    end
    rd(`CCA_ADR_FLAG, 16'h005F);
    repeat (3) @(posedge clk);
    stop_test();
  end
endmodule : capture_compare_array_bench
